// >>> rtl/scan_tap_instruction_logic.v
/*
  test access port for a synchronous memory: sixteen-state controller,
  three-bit instruction register, id, bypass and boundary scan chains.
  assumes the scan clock, mode select and data in arrive asynchronously
  and are oversampled by ref_clk_i, which runs well above the 20 MHz limit.
*/
// How it works
// - three-bit instruction register, eight codes, three reserved and treated as bypass when loaded
// - shifted instruction becomes active only at update-instruction
// - identification instruction captures and shifts out a fixed 32-bit code
// - identification instruction loaded at power-up and in test-logic-reset
// - sample-with-float puts boundary register on the chain in data-shift
// - sample-with-float floats the read bus until next update-instruction or test-logic-reset
// - sample/preload captures all pins into boundary register at capture-data
// - after capture, boundary register shifts between serial in and out
// - preload moves shifted pattern to latched parallel cell outputs
// - one shift pass outputs captured data while taking in preload data
// - bypass instruction puts the single bypass bit on the chain
// - external test drives latched cells to pins and shifts boundary chain
// - boundary cell 47 latched value is the read bus enable in external test
// - in external test, enable high drives read bus, low floats it
// - enable cell value latched into preload stage at update-data
// - latched enable preset high at power-up and in test-logic-reset
// - state machine advances on each rising scan clock using mode select
// - inputs sampled on rising scan clock, serial output changes on falling
// - capture-instruction loads binary 01 into the two low bits
// - five rising edges with mode select high reset the test logic
// - bypass register is one bit, cleared when bypass captures
`timescale 1ns/10ps
`default_nettype none
`include "scan_tap_defines.vh"

module scan_tap_instruction_logic #(
  parameter [`ID_WIDTH-1:0] ID_CODE   = 32'h0000_0001, // arbitrary value
  parameter                 BSR_WIDTH = `BSR_WIDTH
) (
  // clock and reset
  input  wire                 ref_clk_i,
  input  wire                 sys_rst_i,
  // scan pins
  input  wire                 tck_i,
  input  wire                 tms_i,
  input  wire                 tdi_i,
  output reg                  tdo_o,
  output reg                  tdo_oe_o,
  // memory pin ring
  input  wire [BSR_WIDTH-1:0] pin_sample_i,
  output reg  [BSR_WIDTH-1:0] pin_drive_o,
  output reg                  pin_drive_en_o,
  output reg                  rdata_oe_o,
  // status
  output reg  [`IR_WIDTH-1:0] active_instr_o,
  output reg  [3:0]           tap_state_o
);

  // synchronisers
  reg  [2:0]           tck_sync_reg;
  reg  [2:0]           tms_sync_reg;
  reg  [2:0]           tdi_sync_reg;
  reg                  tck_level_reg;
  reg                  tms_level_reg;
  reg                  tdi_level_reg;
  // tap state
  reg  [3:0]           state_reg;
  reg  [3:0]           state_next;
  reg  [`IR_WIDTH-1:0] ir_shift_reg;
  reg  [`IR_WIDTH-1:0] ir_reg;
  reg  [`ID_WIDTH-1:0] id_shift_reg;
  reg                  bypass_reg;
  reg  [BSR_WIDTH-1:0] bsr_shift_reg;
  reg  [BSR_WIDTH-1:0] bsr_latch_reg;
  reg                  serial_reg;
  reg  [2:0]           tms_high_cnt_reg;
  wire                 rise;
  wire                 fall;
  wire                 use_bsr;

  // controller states
  localparam [3:0] S_RESET     = `ST_RESET;
  localparam [3:0] S_IDLE      = `ST_IDLE;
  localparam [3:0] S_SEL_DR    = `ST_SEL_DR;
  localparam [3:0] S_CAP_DR    = `ST_CAP_DR;
  localparam [3:0] S_SHIFT_DR  = `ST_SHIFT_DR;
  localparam [3:0] S_EXIT1_DR  = `ST_EXIT1_DR;
  localparam [3:0] S_PAUSE_DR  = `ST_PAUSE_DR;
  localparam [3:0] S_EXIT2_DR  = `ST_EXIT2_DR;
  localparam [3:0] S_UPD_DR    = `ST_UPD_DR;
  localparam [3:0] S_SEL_IR    = `ST_SEL_IR;
  localparam [3:0] S_CAP_IR    = `ST_CAP_IR;
  localparam [3:0] S_SHIFT_IR  = `ST_SHIFT_IR;
  localparam [3:0] S_EXIT1_IR  = `ST_EXIT1_IR;
  localparam [3:0] S_PAUSE_IR  = `ST_PAUSE_IR;
  localparam [3:0] S_EXIT2_IR  = `ST_EXIT2_IR;
  localparam [3:0] S_UPD_IR    = `ST_UPD_IR;

  function sel_bsr;
    input [`IR_WIDTH-1:0] op;
    begin
      sel_bsr = (op == `OP_EXTEST) || (op == `OP_SAMPLE_Z) || (op == `OP_SAMPLE_PRE);
    end
  endfunction

  // three-stage sampling, accept change once stages two and three agree
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      tck_sync_reg  <= 3'h0;
      tms_sync_reg  <= 3'h7;
      tdi_sync_reg  <= 3'h7;
      tck_level_reg <= 1'b0;
      tms_level_reg <= 1'b1;
      tdi_level_reg <= 1'b1;
    end
    else
    begin
      tck_sync_reg <= {tck_sync_reg[1:0], tck_i};
      tms_sync_reg <= {tms_sync_reg[1:0], tms_i};
      tdi_sync_reg <= {tdi_sync_reg[1:0], tdi_i};
      if (tck_sync_reg[1] == tck_sync_reg[2])
        tck_level_reg <= tck_sync_reg[2];
      if (tms_sync_reg[1] == tms_sync_reg[2])
        tms_level_reg <= tms_sync_reg[2];
      if (tdi_sync_reg[1] == tdi_sync_reg[2])
        tdi_level_reg <= tdi_sync_reg[2];
    end
  end

  assign rise    = (tck_sync_reg[1] == tck_sync_reg[2]) && tck_sync_reg[2] && !tck_level_reg;
  assign fall    = (tck_sync_reg[1] == tck_sync_reg[2]) && !tck_sync_reg[2] && tck_level_reg;
  assign use_bsr = sel_bsr(ir_reg);

  // controller next state
  always @*
  begin
    case (state_reg)
      S_RESET:    state_next = tms_level_reg ? S_RESET    : S_IDLE;
      S_IDLE:     state_next = tms_level_reg ? S_SEL_DR   : S_IDLE;
      S_SEL_DR:   state_next = tms_level_reg ? S_SEL_IR   : S_CAP_DR;
      S_CAP_DR:   state_next = tms_level_reg ? S_EXIT1_DR : S_SHIFT_DR;
      S_SHIFT_DR: state_next = tms_level_reg ? S_EXIT1_DR : S_SHIFT_DR;
      S_EXIT1_DR: state_next = tms_level_reg ? S_UPD_DR   : S_PAUSE_DR;
      S_PAUSE_DR: state_next = tms_level_reg ? S_EXIT2_DR : S_PAUSE_DR;
      S_EXIT2_DR: state_next = tms_level_reg ? S_UPD_DR   : S_SHIFT_DR;
      S_UPD_DR:   state_next = tms_level_reg ? S_SEL_DR   : S_IDLE;
      S_SEL_IR:   state_next = tms_level_reg ? S_RESET    : S_CAP_IR;
      S_CAP_IR:   state_next = tms_level_reg ? S_EXIT1_IR : S_SHIFT_IR;
      S_SHIFT_IR: state_next = tms_level_reg ? S_EXIT1_IR : S_SHIFT_IR;
      S_EXIT1_IR: state_next = tms_level_reg ? S_UPD_IR   : S_PAUSE_IR;
      S_PAUSE_IR: state_next = tms_level_reg ? S_EXIT2_IR : S_PAUSE_IR;
      S_EXIT2_IR: state_next = tms_level_reg ? S_UPD_IR   : S_SHIFT_IR;
      S_UPD_IR:   state_next = tms_level_reg ? S_SEL_DR   : S_IDLE;
      default:    state_next = S_RESET;
    endcase
    if (tms_level_reg && (tms_high_cnt_reg == `RESET_TMS_EDGES - 3'h1))
      state_next = S_RESET;
  end

  // mode select high count, forces reset on the fifth rising edge
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      tms_high_cnt_reg <= 3'h0;
    else if (rise)
    begin
      if (!tms_level_reg)
        tms_high_cnt_reg <= 3'h0;
      else if (tms_high_cnt_reg != `RESET_TMS_EDGES)
        tms_high_cnt_reg <= tms_high_cnt_reg + 3'h1;
    end
  end

  // rising scan clock: state, capture, shift, update
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg     <= `ST_RESET;
      ir_shift_reg  <= `OP_IDCODE;
      ir_reg        <= `OP_IDCODE;
      id_shift_reg  <= {`ID_WIDTH{1'b0}};
      bypass_reg    <= 1'b0;
      bsr_shift_reg <= {BSR_WIDTH{1'b0}};
      bsr_latch_reg <= {BSR_WIDTH{1'b0}};
      bsr_latch_reg[`OE_CELL] <= 1'b1;
    end
    else if (rise)
    begin
      state_reg <= state_next;
      case (state_reg)
        `ST_CAP_IR:
          ir_shift_reg <= {ir_reg[`IR_WIDTH-1], `IR_CAPTURE_LOW};
        `ST_SHIFT_IR:
          ir_shift_reg <= {tdi_level_reg, ir_shift_reg[`IR_WIDTH-1:1]};
        `ST_UPD_IR:
          ir_reg <= ir_shift_reg;
        `ST_CAP_DR:
        begin
          id_shift_reg <= ID_CODE;
          bypass_reg   <= 1'b0;
          if (use_bsr)
            bsr_shift_reg <= pin_sample_i;
        end
        `ST_SHIFT_DR:
        begin
          if (ir_reg == `OP_IDCODE)
            id_shift_reg <= {tdi_level_reg, id_shift_reg[`ID_WIDTH-1:1]};
          else if (use_bsr)
            bsr_shift_reg <= {tdi_level_reg, bsr_shift_reg[BSR_WIDTH-1:1]};
          else
            bypass_reg <= tdi_level_reg;
        end
        `ST_UPD_DR:
          if (use_bsr)
            bsr_latch_reg <= bsr_shift_reg;
        default:
          ;
      endcase
      // entering or staying in test-logic-reset
      if (state_next == S_RESET)
      begin
        ir_reg <= `OP_IDCODE;
        bsr_latch_reg[`OE_CELL] <= 1'b1;
      end
    end
  end

  // chain output select
  always @*
  begin
    if (state_reg == `ST_SHIFT_IR)
      serial_reg = ir_shift_reg[0];
    else if (ir_reg == `OP_IDCODE)
      serial_reg = id_shift_reg[0];
    else if (use_bsr)
      serial_reg = bsr_shift_reg[0];
    else
      serial_reg = bypass_reg;
  end

  // falling scan clock drives serial output; pin outputs from flops
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      tdo_o          <= 1'b0;
      tdo_oe_o       <= 1'b0;
      pin_drive_o    <= {BSR_WIDTH{1'b0}};
      pin_drive_en_o <= 1'b0;
      rdata_oe_o     <= 1'b1;
      active_instr_o <= `OP_IDCODE;
      tap_state_o    <= `ST_RESET;
    end
    else
    begin
      if (fall)
      begin
        tdo_o    <= serial_reg;
        tdo_oe_o <= (state_reg == `ST_SHIFT_IR) || (state_reg == `ST_SHIFT_DR);
      end
      pin_drive_o    <= bsr_latch_reg;
      pin_drive_en_o <= (ir_reg == `OP_EXTEST);
      if (ir_reg == `OP_SAMPLE_Z)
        rdata_oe_o <= 1'b0;
      else if (ir_reg == `OP_EXTEST)
        rdata_oe_o <= bsr_latch_reg[`OE_CELL];
      else
        rdata_oe_o <= 1'b1;
      active_instr_o <= ir_reg;
      tap_state_o    <= state_reg;
    end
  end

endmodule // scan_tap_instruction_logic
`default_nettype wire

// >>> rtl/scan_tap_defines.vh
/*
  constants for the scan tap instruction logic: instruction codes,
  controller states, chain lengths and reset values.
  assumes inclusion by bare name from rtl/.
*/
`ifndef SCAN_TAP_DEFINES_VH
`define SCAN_TAP_DEFINES_VH

`define IR_WIDTH        3
`define OP_EXTEST       3'h0
`define OP_IDCODE       3'h1
`define OP_SAMPLE_Z     3'h2
`define OP_SAMPLE_PRE   3'h4
`define OP_BYPASS       3'h7
`define IR_CAPTURE_LOW  2'h1
`define ID_WIDTH        32
`define BSR_WIDTH       108
`define OE_CELL         47
`define RESET_TMS_EDGES 3'h5

`define ST_RESET        4'h0
`define ST_IDLE         4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SHIFT_DR     4'h4
`define ST_EXIT1_DR     4'h5
`define ST_PAUSE_DR     4'h6
`define ST_EXIT2_DR     4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'hA
`define ST_SHIFT_IR     4'hB
`define ST_EXIT1_IR     4'hC
`define ST_PAUSE_IR     4'hD
`define ST_EXIT2_IR     4'hE
`define ST_UPD_IR       4'hF

`endif

// >>> sim/scan_tap_assertions.sv
/* checker for the scan tap outputs.
   assumes binding into scan_tap_instruction_logic and the defines header. */
`timescale 1ns/10ps
`default_nettype none
`include "scan_tap_defines.vh"
module scan_tap_assertions #(parameter BSR_WIDTH = 108) (
  // clock and reset
  input wire logic                 ref_clk_i,
  input wire logic                 sys_rst_i,
  // watched outputs
  input wire logic                 tdo_oe_o,
  input wire logic                 rdata_oe_o,
  input wire logic                 pin_drive_en_o,
  input wire logic [BSR_WIDTH-1:0] pin_drive_o,
  input wire logic [2:0]           active_instr_o,
  input wire logic [3:0]           tap_state_o
);
  wire upd_w = tap_state_o == `ST_UPD_IR || tap_state_o == `ST_RESET;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_oe; tap_state_o == `ST_RESET |-> !tdo_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("tdo driven in reset");
  property p_sz; (active_instr_o == `OP_SAMPLE_Z)[*2] |-> !rdata_oe_o; endproperty
  a_sz: assert property (p_sz) else $error("read bus on in sample z");
  property p_en; $stable(active_instr_o) |-> pin_drive_en_o == (active_instr_o == 3'h0);
  endproperty
  a_en: assert property (p_en) else $error("pin drive enable wrong");
  property p_rid; (tap_state_o == `ST_RESET)[*2] |-> active_instr_o == `OP_IDCODE; endproperty
  a_rid: assert property (p_rid) else $error("no id instr in reset");
  property p_roe; (tap_state_o == `ST_RESET)[*3] |-> rdata_oe_o; endproperty
  a_roe: assert property (p_roe) else $error("read bus off in reset");
  property p_upd; !$stable(active_instr_o) |-> upd_w || $past(upd_w); endproperty
  a_upd: assert property (p_upd) else $error("instr change off update");
  property p_idl; !$stable(tap_state_o) && $past(tap_state_o) == `ST_RESET
    |-> tap_state_o == `ST_IDLE; endproperty
  a_idl: assert property (p_idl) else $error("bad exit from reset");
  property p_c47; (active_instr_o == 3'h0)[*2] ##0 $stable(rdata_oe_o)
    && $stable(pin_drive_o[`OE_CELL]) |-> rdata_oe_o == pin_drive_o[`OE_CELL]; endproperty
  a_c47: assert property (p_c47) else $error("read bus not from cell");
  c_shdr: cover property (tap_state_o == `ST_SHIFT_DR);
  c_ext: cover property (active_instr_o == `OP_EXTEST);
  c_sz: cover property (active_instr_o == `OP_SAMPLE_Z);
endmodule // scan_tap_assertions
bind scan_tap_instruction_logic scan_tap_assertions #(.BSR_WIDTH(BSR_WIDTH)) u_chk (
  .ref_clk_i, .sys_rst_i, .tdo_oe_o, .rdata_oe_o, .pin_drive_en_o, .pin_drive_o,
  .active_instr_o, .tap_state_o);
`default_nettype wire

// >>> sim/scan_ctrl_model.sv
/* scan controller model: one 40 ns scan clock pulse per step request.
   assumes a 100 MHz ref_clk_i; the scan clock stands low between steps. */
`timescale 1ns/10ps
`default_nettype none
module scan_ctrl_model (
  // bench side
  input  wire logic ref_clk_i,
  input  wire logic step_i,
  input  wire logic tms_bit_i,
  input  wire logic tdi_bit_i,
  output var  logic tdo_q_o = 1'b0,
  output var  logic done_o = 1'b0,
  // scan pins
  input  wire logic tdo_i,
  output var  logic tck_o = 1'b0,
  output var  logic tms_o = 1'b1,
  output var  logic tdi_o = 1'b1
);
  logic [3:0] cnt_reg = 4'h0;
  always @(posedge ref_clk_i)
  begin
    done_o <= cnt_reg == 4'h6;
    if (step_i)
    begin
      cnt_reg <= 4'h1;
      tms_o <= tms_bit_i;
      tdi_o <= tdi_bit_i;
    end
    else if (cnt_reg != 4'h0)
      cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
    if (cnt_reg == 4'h5)
      tdo_q_o <= tdo_i;
    tck_o <= cnt_reg >= 4'h4 && cnt_reg < 4'h8;
  end
endmodule // scan_ctrl_model
`default_nettype wire

// >>> sim/scan_tap_instruction_logic_tb.sv
/* bench for scan_tap_instruction_logic: scans the five defined instructions (not the three reserved codes) through
   the controller model and checks chains and pins against a bench model.
   assumes the defines header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "scan_tap_defines.vh"
module scan_tap_instruction_logic_tb;
  localparam [31:0] ID = 32'h5A3C_0F01; // arbitrary value
  localparam [14:0] CODES = {`OP_IDCODE, `OP_BYPASS, `OP_SAMPLE_Z, `OP_EXTEST, `OP_SAMPLE_PRE};
  reg          ref_clk_i = 0, sys_rst_i = 1, step_r = 0, tms_r = 1, tdi_r = 0;
  reg  [107:0] pin_sample_i = 0, pat, d, drv;
  reg  [16:0]  seed = 17'h100E3;
  reg  [2:0]   op, ir;
  integer      k, miscompares = 0, comparisons = 0;
  wire         tck_i, tms_i, tdi_i, tdo_o, tdo_q, done;
  wire         tdo_oe_o, pin_drive_en_o, rdata_oe_o;
  wire [107:0] pin_drive_o;
  wire [2:0]   active_instr_o;
  wire [3:0]   tap_state_o;
  always #5 ref_clk_i = ~ref_clk_i;
  scan_tap_instruction_logic #(.ID_CODE(ID)) u_scan_tap_instruction_logic (.ref_clk_i,
    .sys_rst_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .pin_sample_i, .pin_drive_o,
    .pin_drive_en_o, .rdata_oe_o, .active_instr_o, .tap_state_o);
  scan_ctrl_model u_scan_ctrl_model (.ref_clk_i, .step_i(step_r), .tms_bit_i(tms_r),
    .tdi_bit_i(tdi_r), .tdo_i(tdo_oe_o ? tdo_o : ~tdo_o), .tck_o(tck_i), .tms_o(tms_i),
    .tdi_o(tdi_i), .tdo_q_o(tdo_q), .done_o(done));
  function [16:0] lfsr(input [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction
  task print_verdict;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [107:0] e, input [107:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task step(input t, input b);
    integer w;
    begin
      step_r <= 1;
      tms_r <= t;
      tdi_r <= b;
      @(posedge ref_clk_i);
      step_r <= 0;
      for (w = 0; w < 20 && done !== 1'b1; w = w + 1) @(posedge ref_clk_i);
      if (w == 20) miscompares = miscompares + 1;
      if (w == 20) print_verdict;
    end
  endtask
  task scan(input irp, input integer n, input [107:0] din);
    integer i;
    begin
      step(1, 0);
      if (irp) step(1, 0);
      step(0, 0);
      step(0, 0);
      for (i = 0; i < n; i = i + 1)
      begin
        step(i == n - 1, din[i]);
        d[i] = tdo_q;
      end
      if (irp) chk("hold", ir, active_instr_o);
      step(1, 0);
      step(0, 0);
      repeat (4) @(posedge ref_clk_i);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    repeat (4) @(posedge ref_clk_i);
    chk("instr", `OP_IDCODE, active_instr_o);
    chk("rdoe", 1, rdata_oe_o);
    ir = `OP_IDCODE;
    step(0, 0);
    chk("tdo_oe", 0, tdo_oe_o);
    for (k = 0; k < 5; k = k + 1)
    begin
      op = CODES[3*k +: 3];
      scan(1, 3, op);
      chk("ircap", 2'h1, d[1:0]);
      ir = op;
      chk("instr", ir, active_instr_o);
      repeat (7)
      begin
        seed = lfsr(seed);
        pat = {pat[90:0], seed};
      end
      pat[`OE_CELL] = ~k[0];
      pin_sample_i <= ~pat;
      scan(0, 108, pat);
      if (op == `OP_BYPASS) chk("byp", {pat[106:0], 1'b0}, d);
      else if (op == `OP_IDCODE) chk("id", ID, d[31:0]);
      else chk("bsr", ~pat, d);
      if (op == 3'h0 || op == 3'h2 || op == 3'h4) drv = pat;
      chk("drive", drv, pin_drive_o);
      chk("drv_en", op == `OP_EXTEST, pin_drive_en_o);
      chk("rdoe", op == 3'h2 ? 1'b0 : op == 3'h0 ? drv[`OE_CELL] : 1'b1, rdata_oe_o);
    end
    repeat (5) step(1, 0);
    repeat (4) @(posedge ref_clk_i);
    chk("state", `ST_RESET, tap_state_o);
    chk("instr", `OP_IDCODE, active_instr_o);
    ir = `OP_IDCODE;
    step(0, 0);
    scan(1, 3, `OP_EXTEST);
    chk("rdoe", 1, rdata_oe_o);
    print_verdict;
  end
endmodule // scan_tap_instruction_logic_tb
`default_nettype wire
